// ---- hdl/wdfs_pkg.sv ----
// package of constants for the watchdog and fail-safe supervisor
package wdfs_pkg;
	// =========================================================
	// widths and timing
	localparam int          WDFS_CH_COUNT   = 12;
	localparam int          WDFS_CNT_W      = 32;
	localparam int          WDFS_CLK_MHZ    = 100;
	// default watchdog window in microseconds, plain values
	localparam int          WDFS_TMIN_US    = 10;
	localparam int          WDFS_TMAX_US    = 100;
	localparam int          WDFS_TMIN_CYC   = WDFS_TMIN_US * WDFS_CLK_MHZ;
	localparam int          WDFS_TMAX_CYC   = WDFS_TMAX_US * WDFS_CLK_MHZ;
	// =========================================================
	// reset values and serial bit count end
	localparam logic [11:0] WDFS_FAULT_RST  = 12'h000;
	localparam logic [11:0] WDFS_SHIFT_RST  = 12'h000;
	localparam logic [31:0] WDFS_CNT_RST    = 32'h0000_0000;
	localparam logic [3:0]  WDFS_BIT_RST    = 4'h0;
	localparam logic [3:0]  WDFS_BIT_TOP    = 4'hB;

	// supervisor states, gray along standby, run, failsafe
	typedef enum logic [1:0] {
		WDFS_ST_STANDBY  = 2'b00,
		WDFS_ST_RUN      = 2'b01,
		WDFS_ST_FAILSAFE = 2'b11
	} wdfs_state_t;
endpackage : wdfs_pkg

// ---- hdl/wdfs_supervisor.sv ----
// watchdog, fail-safe and fault reporting supervisor
// Operation
// - reset clears fault and serial report registers
// - reset holds the device in low-current standby
// - reset release starts the watchdog timeout interval
// - fail-safe with select high turns on high-side outputs 0 and 2
// - select low disables watchdog supervision and fail-safe entry
// - no kick transition within timeout window enters fail-safe
// - open-drain fault flag pulled low from any output fault until the next fault read start
// - fault flag is summary only; serial output names faulted outputs
// - watchdog timing enabled only while wake input is high
// - fail-safe outputs stay on while select stays high, until reinitialized, then normal operation
// - serial fault bits for outputs 11 down to 0, msb first
`timescale 1ns/100ps
module wdfs_supervisor #(
	parameter int TMIN_CYC = wdfs_pkg::WDFS_TMIN_CYC,
	parameter int TMAX_CYC = wdfs_pkg::WDFS_TMAX_CYC
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        failsafe_select_in,
	input  wire logic        watchdog_kick_in,
	input  wire logic        wake_in,
	input  wire logic [11:0] output_fault_in,
	input  wire logic [1:0]  high_side_cmd_in,
	input  wire logic        fault_read_start,
	output logic             high_side_out_zero,
	output logic             high_side_out_two,
	output logic             fault_flag_n_out,
	output logic             fault_flag_n_oe,
	output logic             fault_serial_out,
	output logic             fault_serial_valid,
	output logic             standby,
	output logic             failsafe_active
);
	// =========================================================
	// input synchronisers
	logic [4:0] sync1_reg;
	logic [4:0] sync1_next;
	logic [4:0] sync2_reg;
	logic [4:0] sync2_next;
	logic       kick_prev_reg;
	logic       kick_prev_next;
	logic [11:0] fsync1_reg;
	logic [11:0] fsync2_reg;
	logic       fsel;
	logic       kick;
	logic       wake;
	logic       hs0_cmd;
	logic       hs2_cmd;

	always_comb begin
		sync1_next     = {failsafe_select_in, watchdog_kick_in, wake_in, high_side_cmd_in};
		sync2_next     = sync1_reg;
		kick_prev_next = sync2_reg[3];
	end

	always_ff @(posedge clk) begin
		sync1_reg     <= sync1_next;
		sync2_reg     <= sync2_next;
		kick_prev_reg <= kick_prev_next;
		fsync1_reg    <= output_fault_in;
		fsync2_reg    <= fsync1_reg;
	end

	assign fsel    = sync2_reg[4];
	assign kick    = sync2_reg[3];
	assign wake    = sync2_reg[2];
	assign hs2_cmd = sync2_reg[1];
	assign hs0_cmd = sync2_reg[0];

	// =========================================================
	// watchdog state machine
	wdfs_pkg::wdfs_state_t        state_reg;
	wdfs_pkg::wdfs_state_t        state_next;
	logic [wdfs_pkg::WDFS_CNT_W-1:0] cnt_reg;
	logic [wdfs_pkg::WDFS_CNT_W-1:0] cnt_next;
	logic                         kick_edge;
	logic                         too_late;
	logic                         too_early;

	assign kick_edge = kick ^ kick_prev_reg;
	assign too_late  = cnt_reg >= TMAX_CYC[wdfs_pkg::WDFS_CNT_W-1:0];
	assign too_early = cnt_reg < TMIN_CYC[wdfs_pkg::WDFS_CNT_W-1:0];

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			wdfs_pkg::WDFS_ST_STANDBY: begin
				// first edge after reset release starts the interval
				state_next = wdfs_pkg::WDFS_ST_RUN;
				cnt_next   = wdfs_pkg::WDFS_CNT_RST;
			end
			wdfs_pkg::WDFS_ST_RUN: begin
				if (!fsel || !wake) begin
					// supervision off; keep interval fresh
					cnt_next = wdfs_pkg::WDFS_CNT_RST;
				end else if (kick_edge && !too_early) begin
					cnt_next = wdfs_pkg::WDFS_CNT_RST;
				end else if (kick_edge || too_late) begin
					// early or missing kick is a timeout
					state_next = wdfs_pkg::WDFS_ST_FAILSAFE;
				end else begin
					cnt_next = cnt_reg + 32'h0000_0001;
				end
			end
			wdfs_pkg::WDFS_ST_FAILSAFE: begin
				// held until reset reinitializes the device
				state_next = wdfs_pkg::WDFS_ST_FAILSAFE;
			end
			default: begin
				state_next = wdfs_pkg::WDFS_ST_STANDBY;
				cnt_next   = wdfs_pkg::WDFS_CNT_RST;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_reg <= wdfs_pkg::WDFS_ST_STANDBY;
			cnt_reg   <= wdfs_pkg::WDFS_CNT_RST;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
		end
	end

	// =========================================================
	// fault latch and serial fault report
	logic [11:0] fault_reg;
	logic [11:0] fault_next;
	logic [11:0] shift_reg;
	logic [11:0] shift_next;
	logic [3:0]  bit_reg;
	logic [3:0]  bit_next;
	logic        busy_reg;
	logic        busy_next;
	logic        sout_reg;
	logic        sout_next;

	always_comb begin
		// faults stick until reported; a new fault wins over the clear
		fault_next = fault_reg | fsync2_reg;
		shift_next = shift_reg;
		bit_next   = bit_reg;
		busy_next  = busy_reg;
		sout_next  = 1'b0;
		if (!busy_reg && fault_read_start && state_reg != wdfs_pkg::WDFS_ST_STANDBY) begin
			shift_next = fault_reg;
			fault_next = fsync2_reg;
			bit_next   = wdfs_pkg::WDFS_BIT_RST;
			busy_next  = 1'b1;
		end else if (busy_reg) begin
			sout_next  = shift_reg[11];
			shift_next = {shift_reg[10:0], 1'b0};
			bit_next   = bit_reg + 4'h1;
			if (bit_reg == wdfs_pkg::WDFS_BIT_TOP) begin
				busy_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			fault_reg <= wdfs_pkg::WDFS_FAULT_RST;
			shift_reg <= wdfs_pkg::WDFS_SHIFT_RST;
			bit_reg   <= wdfs_pkg::WDFS_BIT_RST;
			busy_reg  <= 1'b0;
			sout_reg  <= 1'b0;
		end else begin
			fault_reg <= fault_next;
			shift_reg <= shift_next;
			bit_reg   <= bit_next;
			busy_reg  <= busy_next;
			sout_reg  <= sout_next;
		end
	end

	// =========================================================
	// outputs
	logic fs_on;
	logic hs0_reg;
	logic hs0_next;
	logic hs2_reg;
	logic hs2_next;
	logic flag_reg;
	logic flag_next;
	logic sout_valid_reg;
	logic sout_valid_next;

	assign fs_on = (state_reg == wdfs_pkg::WDFS_ST_FAILSAFE) && fsel;

	always_comb begin
		hs0_next        = fs_on | (state_reg == wdfs_pkg::WDFS_ST_RUN && hs0_cmd);
		hs2_next        = fs_on | (state_reg == wdfs_pkg::WDFS_ST_RUN && hs2_cmd);
		flag_next       = |fault_next;
		sout_valid_next = busy_reg;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			hs0_reg        <= 1'b0;
			hs2_reg        <= 1'b0;
			flag_reg       <= 1'b0;
			sout_valid_reg <= 1'b0;
		end else begin
			hs0_reg        <= hs0_next;
			hs2_reg        <= hs2_next;
			flag_reg       <= flag_next;
			sout_valid_reg <= sout_valid_next;
		end
	end

	assign high_side_out_zero = hs0_reg;
	assign high_side_out_two  = hs2_reg;
	assign fault_flag_n_out   = 1'b0;
	assign fault_flag_n_oe    = flag_reg;
	assign fault_serial_out   = sout_reg;
	assign fault_serial_valid = sout_valid_reg;
	assign standby            = state_reg == wdfs_pkg::WDFS_ST_STANDBY;
	assign failsafe_active    = state_reg == wdfs_pkg::WDFS_ST_FAILSAFE;
endmodule : wdfs_supervisor

// ---- test/wdfs_supervisor_chk.sv ----
// concurrent checks on the supervisor ports
`timescale 1ns/100ps
module wfc_chk (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        failsafe_select_in,
	input wire logic [11:0] output_fault_in,
	input wire logic        fault_read_start,
	input wire logic        high_side_out_zero,
	input wire logic        high_side_out_two,
	input wire logic        fault_flag_n_out,
	input wire logic        fault_flag_n_oe,
	input wire logic        fault_serial_valid,
	input wire logic        standby,
	input wire logic        failsafe_active
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence ser_burst;
		fault_serial_valid [*8] ##1 fault_serial_valid [*4] ##1 !fault_serial_valid;
	endsequence
	rst_standby_a: assert property (disable iff (1'b0) !resetn |=> standby && !fault_flag_n_oe
		&& !high_side_out_zero && !high_side_out_two) else $error("reset not standby");
	rel_run_a: assert property ($rose(resetn) |=> !standby) else $error("no run after reset");
	fs_out_a: assert property ($rose(failsafe_active) |=> high_side_out_zero
		&& high_side_out_two) else $error("fail-safe outputs off");
	fsel_off_a: assert property (!failsafe_select_in [*4] ##1 !failsafe_active
		|=> !failsafe_active) else $error("fail-safe with select low");
	fs_hold_a: assert property (failsafe_active |=> failsafe_active) else $error("fail-safe left");
	flag_rise_a: assert property ($rose(|output_fault_in) |-> ##[2:5] fault_flag_n_oe)
		else $error("fault flag not raised");
	flag_low_a: assert property (fault_flag_n_oe |-> !fault_flag_n_out) else $error("flag not low");
	ser_len_a: assert property ($rose(fault_read_start) && !standby && !fault_serial_valid
		&& !$past(fault_serial_valid) |-> ##2 ser_burst) else $error("short report");
endmodule : wfc_chk
bind wdfs_supervisor wfc_chk wfc_chk_inst (.*);

// ---- test/wfc_mcu_model.sv ----
// supervising controller model: reset and watchdog kicks
`timescale 1ns/100ps
module wfc_mcu_model (
	input  wire logic       clk,
	input  wire logic       rst_req,
	input  wire logic       kick_en,
	input  wire logic [7:0] kick_gap,
	output logic            resetn,
	output logic            watchdog_kick_in
);
	int gap;
	initial begin
		resetn = 1'b0;
		watchdog_kick_in = 1'b0;
		gap = 0;
		forever begin
			@(posedge clk);
			resetn <= #1 !rst_req;
			if (!kick_en || !resetn) gap = 0;
			else if (gap == kick_gap) begin
				watchdog_kick_in <= #1 !watchdog_kick_in;
				gap = 0;
			end else gap++;
		end
	end
endmodule : wfc_mcu_model

// ---- test/watchdog_failsafe_control_test.sv ----
// self-checking bench for the watchdog and fail-safe supervisor
`timescale 1ns/100ps
module watchdog_failsafe_control_test;
	logic        clk, resetn, failsafe_select_in, watchdog_kick_in, wake_in, fault_read_start;
	logic [11:0] output_fault_in, bits;
	logic [1:0]  high_side_cmd_in;
	logic        high_side_out_zero, high_side_out_two, fault_flag_n_out, fault_flag_n_oe;
	logic        fault_serial_out, fault_serial_valid, standby, failsafe_active, rst_req, kick_en;
	int          mismatches, samples_checked;
	wdfs_supervisor #(.TMIN_CYC(20), .TMAX_CYC(100)) wdfs_supervisor_inst (.*);
	wfc_mcu_model wfc_mcu_model_inst (.clk(clk), .rst_req(rst_req), .kick_en(kick_en),
		.kick_gap(8'h32), .resetn(resetn), .watchdog_kick_in(watchdog_kick_in));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic do_reset(input int n);
		rst_req = 1'b1;
		cyc(n);
		chk("standby", standby, 1'b1);
		chk("hs0", high_side_out_zero, 1'b0);
		rst_req = 1'b0;
		cyc(4);
		chk("run", standby, 1'b0);
		chk("no fs", failsafe_active, 1'b0);
		high_side_cmd_in = 2'h1;
		cyc(4);
		chk("normal", {high_side_out_zero, high_side_out_two}, 2'b10);
		high_side_cmd_in = 2'h0;
	endtask : do_reset
	task automatic t_timeout();
		cyc(400);
		chk("kicked", failsafe_active, 1'b0);
		kick_en = 1'b0;
		for (int i = 0; i < 150 && failsafe_active !== 1'b1; i++) cyc(1);
		chk("timeout", failsafe_active, 1'b1);
		cyc(50);
		chk("fs outs", {high_side_out_zero, high_side_out_two}, 2'b11);
	endtask : t_timeout
	task automatic t_disable();
		failsafe_select_in = 1'b0;
		do_reset(3);
		cyc(300);
		chk("fsel low", failsafe_active, 1'b0);
		failsafe_select_in = 1'b1;
		wake_in = 1'b0;
		do_reset(3);
		cyc(300);
		chk("wake low", failsafe_active, 1'b0);
	endtask : t_disable
	task automatic t_report();
		output_fault_in = 12'hA53;
		cyc(6);
		chk("flag", fault_flag_n_oe, 1'b1);
		output_fault_in = 12'h000;
		// let the cleared pins pass the synchroniser before the capture
		cyc(3);
		fault_read_start = 1'b1;
		cyc(1);
		fault_read_start = 1'b0;
		for (int i = 0; i < 6 && fault_serial_valid !== 1'b1; i++) cyc(1);
		for (int i = 0; i < 12; i++) begin
			bits = {bits[10:0], fault_serial_out};
			cyc(1);
		end
		chk("report", bits, 12'hA53);
		cyc(4);
		chk("flag clear", fault_flag_n_oe, 1'b0);
	endtask : t_report
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : close_out
	initial begin
		#50000;
		mismatches++;
		close_out();
	end
	initial begin
		{mismatches, samples_checked} = '0;
		{failsafe_select_in, wake_in, kick_en} = 3'h7;
		{output_fault_in, high_side_cmd_in, fault_read_start, bits} = '0;
		do_reset(20);
		t_timeout();
		t_disable();
		t_report();
		close_out();
	end
endmodule : watchdog_failsafe_control_test
